// *** rtl/usc_top.sv ***
// serial port control: transmit fifo, apb registers, tx and rx engines
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

module usc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two for the wrap-bit pointers
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("usc_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wptr_reg[AW] != rptr_reg[AW]) &&
                      (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]));
  assign out_valid = (wptr_reg != rptr_reg);
  assign out_data = mem[rptr_reg[AW-1:0]];

  // write side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
    end else if (ce && in_valid && in_ready) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (ce && in_valid && in_ready) begin
      mem[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  // read side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr_reg <= '0;
    end else if (ce && out_valid && out_ready) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end
endmodule // usc_fifo

module usc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer1_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);
  usc_pkg::usc_serial_control_s serial_control_reg;
  usc_pkg::usc_power_control_s power_control_reg;
  usc_pkg::usc_tx_state_e tx_st_reg;
  usc_pkg::usc_rx_state_e rx_st_reg;
  logic frame_err_reg;
  logic [7:0] given_reg;
  logic [7:0] bcast_reg;
  logic [7:0] rx_data_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic s1_reg, s2_reg, s3_reg, rx_filt_reg, rx_prev_reg;
  logic [5:0] tx_cnt_reg, rx_cnt_reg;
  logic [3:0] tx_bit_reg, rx_bit_reg;
  logic [8:0] tx_shift_reg, rx_shift_reg;
  logic txd_reg, rxd_out_reg, rxd_oe_reg;
  logic mode0, mode1, nine, fast, tick;
  logic [5:0] tpb, half;
  logic tx_end, rx_mid, rx_end, rx_set, accept, addr_hit;
  logic [7:0] rx_byte;
  logic acc, wr, rd_ok, tx_push, fifo_in_ready, fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  logic clk_lvl;

  // mode decode from the two mode bits
  assign mode0 = !serial_control_reg.mode_select_low && !serial_control_reg.mode_select_high;
  assign mode1 = !serial_control_reg.mode_select_low && serial_control_reg.mode_select_high;
  assign nine = serial_control_reg.mode_select_low;

  // timer clock select
  // system clock drives mode 2, and shift mode with tx_ninth_bit clear; timer overflow otherwise
  assign fast = (mode0 && !serial_control_reg.tx_ninth_bit) ||
                (nine && !serial_control_reg.mode_select_high);
  assign tick = pclk_en && (fast || timer1_ovf);

  assign tpb = (mode0 ? usc_pkg::M0_TICKS : usc_pkg::UART_TICKS) >>
               power_control_reg.baud_doubler;
  assign half = tpb >> 1;

  // apb decode: one wait-free access, stalls only on a full fifo
  assign acc = psel && penable && pclk_en;
  assign tx_push = acc && pwrite && (paddr == usc_pkg::TXDATA_OFS);
  assign pready = !(psel && penable && pwrite &&
                    (paddr == usc_pkg::TXDATA_OFS) && !fifo_in_ready);
  assign wr = acc && pwrite && pready;
  assign rd_ok = (paddr == usc_pkg::SERIAL_CONTROL_OFS) ||
                 (paddr == usc_pkg::POWER_CONTROL_OFS) ||
                 (paddr == usc_pkg::TXDATA_OFS) ||
                 (paddr == usc_pkg::RXDATA_OFS) ||
                 (paddr == usc_pkg::MATCH_OFS) ||
                 (paddr == usc_pkg::STATUS_OFS);
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (pclk_en && psel && !penable) begin
      pslverr_reg <= !rd_ok;
      case (paddr)
        usc_pkg::SERIAL_CONTROL_OFS: prdata_reg <= {24'h000000,
          (power_control_reg.frame_err_select ? frame_err_reg :
           serial_control_reg.mode_select_low), serial_control_reg[6:0]};
        usc_pkg::POWER_CONTROL_OFS: prdata_reg <= {24'h000000, power_control_reg, 6'h00};
        usc_pkg::RXDATA_OFS: prdata_reg <= {24'h000000, rx_data_reg};
        usc_pkg::MATCH_OFS: prdata_reg <= {16'h0000, bcast_reg, given_reg};
        usc_pkg::STATUS_OFS: prdata_reg <= {28'h0000000, !fifo_in_ready,
          fifo_valid, rx_st_reg != usc_pkg::RX_IDLE,
          tx_st_reg != usc_pkg::TX_IDLE};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // power_control and match registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_reg <= usc_pkg::POWER_CONTROL_RST;
      given_reg <= usc_pkg::GIVEN_RST;
      bcast_reg <= usc_pkg::BCAST_RST;
    end else if (wr && paddr == usc_pkg::POWER_CONTROL_OFS) begin
      power_control_reg.frame_err_select <= pwdata[usc_pkg::POWER_CONTROL_FES_BIT];
      power_control_reg.baud_doubler <= pwdata[usc_pkg::POWER_CONTROL_DBL_BIT];
    end else if (wr && paddr == usc_pkg::MATCH_OFS) begin
      given_reg <= pwdata[usc_pkg::MATCH_GIVEN_LSB +: 8];
      bcast_reg <= pwdata[usc_pkg::MATCH_BCAST_LSB +: 8];
    end
  end

  // serial_control: software writes first, hardware sets win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg <= usc_pkg::SERIAL_CONTROL_RST;
      frame_err_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (pclk_en) begin
      if (wr && paddr == usc_pkg::SERIAL_CONTROL_OFS) begin
        if (!power_control_reg.frame_err_select) begin
          serial_control_reg.mode_select_low <= pwdata[7];
        end else begin
          frame_err_reg <= pwdata[7];
        end
        serial_control_reg[6:0] <= pwdata[6:0];
      end
      if (tx_end && tx_st_reg == usc_pkg::TX_DATA && tx_bit_reg == 4'h7 &&
          !nine) begin
        serial_control_reg.tx_done_flag <= 1'b1;
      end else if (tx_end && tx_st_reg == usc_pkg::TX_DATA &&
                   tx_bit_reg == 4'h8) begin
        serial_control_reg.tx_done_flag <= 1'b1;
      end
      if (rx_st_reg == usc_pkg::RX_STOP && rx_mid && !rx_filt_reg) begin
        frame_err_reg <= 1'b1;
      end
      if (rx_set) begin
        serial_control_reg.rx_done_flag <= 1'b1;
        rx_data_reg <= rx_byte;
        if (nine) begin
          serial_control_reg.rx_ninth_bit <= rx_shift_reg[8];
        end else if (mode1 && !serial_control_reg.multiproc_enable) begin
          serial_control_reg.rx_ninth_bit <= rx_filt_reg;
        end
      end
    end
  end

  // transmit fifo in the data path
  usc_fifo #(
    .WIDTH(usc_pkg::FIFO_WIDTH),
    .DEPTH(usc_pkg::FIFO_DEPTH)
  ) u_txfifo (
    .clk(pclk),
    .rst_n(presetn),
    .ce(pclk_en),
    .in_valid(tx_push),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // a byte leaves the fifo only when the shifter is free
  assign fifo_pop = (tx_st_reg == usc_pkg::TX_IDLE) &&
                    (rx_st_reg == usc_pkg::RX_IDLE || !mode0);
  assign tx_end = tick && (tx_cnt_reg == tpb - 6'h01);

  // transmit engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= usc_pkg::TX_IDLE;
      tx_cnt_reg <= 6'h00;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 9'h1ff;
    end else if (pclk_en) begin
      case (tx_st_reg)
        usc_pkg::TX_IDLE: begin
          tx_cnt_reg <= 6'h00;
          tx_bit_reg <= 4'h0;
          if (fifo_valid && fifo_pop) begin
            tx_shift_reg <= {serial_control_reg.tx_ninth_bit, fifo_data};
            tx_st_reg <= mode0 ? usc_pkg::TX_DATA : usc_pkg::TX_START;
          end
        end
        usc_pkg::TX_START: begin
          if (tick) tx_cnt_reg <= tx_end ? 6'h00 : tx_cnt_reg + 6'h01;
          if (tx_end) tx_st_reg <= usc_pkg::TX_DATA;
        end
        usc_pkg::TX_DATA: begin
          if (tick) tx_cnt_reg <= tx_end ? 6'h00 : tx_cnt_reg + 6'h01;
          if (tx_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == (nine ? 4'h8 : 4'h7)) begin
              tx_st_reg <= mode0 ? usc_pkg::TX_IDLE : usc_pkg::TX_STOP;
            end
          end
        end
        usc_pkg::TX_STOP: begin
          if (tick) tx_cnt_reg <= tx_end ? 6'h00 : tx_cnt_reg + 6'h01;
          if (tx_end) tx_st_reg <= usc_pkg::TX_IDLE;
        end
        default: tx_st_reg <= usc_pkg::TX_IDLE;
      endcase
    end
  end

  // pin input: three flops, a change counts when the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      rx_filt_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else if (pclk_en) begin
      s1_reg <= rxd_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) rx_filt_reg <= s3_reg;
      rx_prev_reg <= rx_filt_reg;
    end
  end

  assign rx_mid = tick && (rx_cnt_reg == half - 6'h01);
  assign rx_end = tick && (rx_cnt_reg == tpb - 6'h01);
  assign rx_byte = nine ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
  assign addr_hit = (rx_byte == given_reg) || (rx_byte == bcast_reg);

  assign accept = !serial_control_reg.multiproc_enable ? 1'b1 :
                  nine ? (rx_shift_reg[8] && addr_hit) :
                  (rx_filt_reg && addr_hit);
  assign rx_set = pclk_en &&
    ((rx_st_reg == usc_pkg::RX_STOP && rx_mid && accept) ||
     (mode0 && rx_st_reg == usc_pkg::RX_DATA && rx_end &&
      rx_bit_reg == 4'h8));

  // receive engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg <= usc_pkg::RX_IDLE;
      rx_cnt_reg <= 6'h00;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else if (pclk_en) begin
      case (rx_st_reg)
        usc_pkg::RX_IDLE: begin
          rx_cnt_reg <= 6'h00;
          rx_bit_reg <= 4'h0;
          if (serial_control_reg.rx_enable) begin
            if (mode0 && !serial_control_reg.rx_done_flag &&
                tx_st_reg == usc_pkg::TX_IDLE && !fifo_valid) begin
              rx_st_reg <= usc_pkg::RX_DATA;
            end else if (!mode0 && rx_prev_reg && !rx_filt_reg) begin
              rx_st_reg <= usc_pkg::RX_START;
            end
          end
        end
        usc_pkg::RX_START: begin
          if (tick) rx_cnt_reg <= rx_end ? 6'h00 : rx_cnt_reg + 6'h01;
          if (rx_mid && rx_filt_reg) begin
            rx_st_reg <= usc_pkg::RX_IDLE;
          end else if (rx_end) begin
            rx_st_reg <= usc_pkg::RX_DATA;
          end
        end
        usc_pkg::RX_DATA: begin
          if (tick) rx_cnt_reg <= rx_end ? 6'h00 : rx_cnt_reg + 6'h01;
          if (rx_mid) begin
            rx_shift_reg <= {rx_filt_reg, rx_shift_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
          end
          if (rx_end && rx_bit_reg == (nine ? 4'h9 : 4'h8)) begin
            rx_st_reg <= mode0 ? usc_pkg::RX_IDLE : usc_pkg::RX_STOP;
          end
        end
        usc_pkg::RX_STOP: begin
          if (tick) rx_cnt_reg <= rx_cnt_reg + 6'h01;
          if (rx_mid) rx_st_reg <= usc_pkg::RX_IDLE;
        end
        default: rx_st_reg <= usc_pkg::RX_IDLE;
      endcase
    end
  end

  // idle at inverse level
  // shift clock pulses away from idle in the first half of each bit
  always_comb begin
    clk_lvl = !serial_control_reg.multiproc_enable;
    if (tx_st_reg == usc_pkg::TX_DATA && tx_cnt_reg < half) begin
      clk_lvl = serial_control_reg.multiproc_enable;
    end
    if (rx_st_reg == usc_pkg::RX_DATA && rx_cnt_reg < half) begin
      clk_lvl = serial_control_reg.multiproc_enable;
    end
  end

  // registered pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_reg <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
    end else if (pclk_en) begin
      if (mode0) begin
        txd_reg <= clk_lvl;
        rxd_out_reg <= tx_shift_reg[0];
        rxd_oe_reg <= (tx_st_reg == usc_pkg::TX_DATA);
      end else begin
        txd_reg <= (tx_st_reg == usc_pkg::TX_START) ? 1'b0 :
                   (tx_st_reg == usc_pkg::TX_DATA) ? tx_shift_reg[0] : 1'b1;
        rxd_out_reg <= 1'b1;
        rxd_oe_reg <= 1'b0;
      end
    end
  end

  assign txd = txd_reg;
  assign rxd_out = rxd_out_reg;
  assign rxd_oe = rxd_oe_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MP_GATE: assert property (
    rx_set && nine && serial_control_reg.multiproc_enable |=>
      serial_control_reg.rx_ninth_bit && serial_control_reg.rx_done_flag &&
      (rx_data_reg == given_reg || rx_data_reg == bcast_reg))
    else $error("nine-bit flag set without address");
  AST_STOP_GATE: assert property (
    rx_set && mode1 && serial_control_reg.multiproc_enable |->
      rx_filt_reg && addr_hit)
    else $error("eight-bit flag set without stop or address");
  AST_IDLE_CLK: assert property (
    pclk_en && mode0 && tx_st_reg == usc_pkg::TX_IDLE &&
    rx_st_reg == usc_pkg::RX_IDLE |=> txd == $past(!serial_control_reg.multiproc_enable))
    else $error("shift clock idle level wrong");
  AST_RX_NINTH: assert property (
    rx_set && nine |=> serial_control_reg.rx_ninth_bit == $past(rx_shift_reg[8]))
    else $error("ninth bit not captured");
  AST_STOP_STORE: assert property (
    rx_set && mode1 && !serial_control_reg.multiproc_enable |=>
      serial_control_reg.rx_ninth_bit == $past(rx_filt_reg))
    else $error("stop bit not stored");
  AST_TI_STOP: assert property (
    $rose(tx_st_reg == usc_pkg::TX_STOP) |-> serial_control_reg.tx_done_flag)
    else $error("tx flag missing at stop start");
  AST_RI_STOP: assert property (
    rx_st_reg == usc_pkg::RX_STOP && rx_mid && pclk_en &&
    !serial_control_reg.multiproc_enable |=> serial_control_reg.rx_done_flag)
    else $error("rx flag missing at stop middle");
  AST_FLAG_HOLD: assert property (
    serial_control_reg.tx_done_flag &&
    !(wr && paddr == usc_pkg::SERIAL_CONTROL_OFS && !pwdata[1]) |=>
      serial_control_reg.tx_done_flag)
    else $error("tx flag cleared by hardware");
  AST_RX_EN: assert property (
    !serial_control_reg.rx_enable && rx_st_reg == usc_pkg::RX_IDLE |=>
      rx_st_reg == usc_pkg::RX_IDLE)
    else $error("reception started while disabled");
endmodule // usc_top

// *** shared/usc_pkg.sv ***
// constants, register layout and state types of the serial control block
package usc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] SERIAL_CONTROL_OFS = 8'h00;
  localparam logic [7:0] POWER_CONTROL_OFS = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0c;
  localparam logic [7:0] MATCH_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // field positions in power_control and the match register
  localparam int POWER_CONTROL_DBL_BIT = 7;
  localparam int POWER_CONTROL_FES_BIT = 6;
  localparam int MATCH_GIVEN_LSB = 0;
  localparam int MATCH_BCAST_LSB = 8;
  // reset values
  localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
  localparam logic [1:0] POWER_CONTROL_RST = 2'h0;
  localparam logic [7:0] GIVEN_RST = 8'h00;
  localparam logic [7:0] BCAST_RST = 8'hff;
  // ticks per bit before the doubler halves them
  localparam logic [5:0] M0_TICKS = 6'h04;
  localparam logic [5:0] UART_TICKS = 6'h20;
  // fifo geometry
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  // serial_control register, msb first
  typedef struct packed {
    logic mode_select_low;
    logic mode_select_high;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } usc_serial_control_s;

  // power_control bits that steer the serial port
  typedef struct packed {
    logic baud_doubler;
    logic frame_err_select;
  } usc_power_control_s;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } usc_tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } usc_rx_state_e;
endpackage

// *** testbench/usc_line_model.sv ***
// far-side serial node: drives the receive pin and samples txd
`timescale 1ns/1ns

module usc_line_model (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  // line idles high between frames
  initial rxd = 1'b1;

  // start bit, data lsb first, stop bit
  task automatic send(input logic [8:0] d, input int n, input logic stp,
                      input int bt);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (bt) @(posedge clk);
    end
    rxd <= stp;
    repeat (bt) @(posedge clk);
    rxd <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask

  // samples one frame from txd in the middle of each bit
  task automatic grab(output logic [8:0] d, output logic ok, input int n,
                      input int bt);
    int w;
    d = 9'h000;
    w = 0;
    while (txd !== 1'b0 && w < 20000) begin
      @(posedge clk);
      w++;
    end
    ok = (w < 20000);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(posedge clk);
      d[i] = txd;
    end
    repeat (bt) @(posedge clk);
    ok = ok && (txd === 1'b1);
  endtask
endmodule // usc_line_model

// *** testbench/usc_top_test.sv ***
// self-checking bench for the serial control block
`timescale 1ns/1ns

module usc_top_test;
  logic pclk, presetn, pclk_en, psel, penable, pwrite, timer1_ovf;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rxd_in, rxd_out, rxd_oe, txd, err, ok;
  logic [8:0] d;
  int num_errors = 0;
  int tests_run = 0;
  int stalls = 0;

  usc_top usc_top_i (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd));
  usc_line_model usc_line_model_i (.clk(pclk), .txd(txd), .rxd(rxd_in));

  // 50 ns clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // counts and verdict
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] v);
    int w;
    w = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready where it is settled, take the answer at the next edge
    @(negedge pclk);
    while (pready !== 1'b1 && w < 5000) begin
      @(negedge pclk);
      w++;
    end
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w > 0) stalls++;
    if (w >= 5000) begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== m && n < 500);
    chk(rd & m, m);
  endtask

  // reset values and an unmapped address
  task automatic t_reset();
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'hffffffff, 32'h0);
    rchk(usc_pkg::POWER_CONTROL_OFS, 32'hffffffff, 32'h0);
    rchk(usc_pkg::MATCH_OFS, 32'hffffffff, 32'hff00);
    rchk(usc_pkg::STATUS_OFS, 32'hffffffff, 32'h0);
    wr(8'h18, 32'h5a);
    chk({31'h0, err}, 32'h1);
    rchk(8'h18, 32'hffffffff, 32'h0);
  endtask

  // mode bit 0 hidden behind the frame error select
  task automatic t_mode_bits();
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h80);
    wr(usc_pkg::POWER_CONTROL_OFS, 32'h40);
    rchk(usc_pkg::POWER_CONTROL_OFS, 32'hff, 32'h40);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'hff, 32'h00);
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h00);
    wr(usc_pkg::POWER_CONTROL_OFS, 32'h00);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'hff, 32'h80);
  endtask

  // shift mode clock idle level and transmit done
  task automatic t_shift();
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h00);
    repeat (4) @(posedge pclk);
    chk({31'h0, txd}, 32'h1);
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h20);
    repeat (4) @(posedge pclk);
    chk({31'h0, txd}, 32'h0);
    wr(usc_pkg::TXDATA_OFS, 32'h5a);
    poll(usc_pkg::SERIAL_CONTROL_OFS, 32'h02);
    repeat (20) @(posedge pclk);
    chk({31'h0, txd}, 32'h0);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h02, 32'h02);
  endtask

  // shift mode on the timer tick: no tick, no progress
  task automatic t_timer();
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h08);
    timer1_ovf <= 1'b0;
    wr(usc_pkg::TXDATA_OFS, 32'h33);
    repeat (50) @(posedge pclk);
    rchk(usc_pkg::STATUS_OFS, 32'h07, 32'h01);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h02, 32'h00);
    timer1_ovf <= 1'b1;
    poll(usc_pkg::SERIAL_CONTROL_OFS, 32'h02);
  endtask

  // nine-bit transmit with the software ninth bit
  task automatic t_tx9(input logic [31:0] mode, input logic [31:0] pc,
                       input int bt);
    wr(usc_pkg::POWER_CONTROL_OFS, pc);
    wr(usc_pkg::SERIAL_CONTROL_OFS, mode | 32'h08);
    fork
      wr(usc_pkg::TXDATA_OFS, 32'ha5);
      usc_line_model_i.grab(d, ok, 9, bt);
    join
    chk({22'h0, ok, d}, 32'h3a5);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h02, 32'h02);
    repeat (300) @(posedge pclk);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h02, 32'h02);
  endtask

  // nine-bit receive with address recognition
  task automatic t_rx9(input logic [31:0] mode);
    wr(usc_pkg::MATCH_OFS, 32'hff3c);
    wr(usc_pkg::SERIAL_CONTROL_OFS, mode | 32'h30);
    usc_line_model_i.send(9'h03c, 9, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h01, 32'h0);
    usc_line_model_i.send(9'h155, 9, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h01, 32'h0);
    usc_line_model_i.send(9'h13c, 9, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h05, 32'h05);
    rchk(usc_pkg::RXDATA_OFS, 32'hff, 32'h3c);
    wr(usc_pkg::SERIAL_CONTROL_OFS, mode | 32'h30);
    usc_line_model_i.send(9'h1ff, 9, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h01, 32'h01);
    rchk(usc_pkg::RXDATA_OFS, 32'hff, 32'hff);
  endtask

  // eight-bit receive: stop bit check and stop bit capture
  task automatic t_rx8();
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h70);
    usc_line_model_i.send(9'h03c, 8, 1'b0, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h01, 32'h0);
    usc_line_model_i.send(9'h011, 8, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h01, 32'h0);
    usc_line_model_i.send(9'h03c, 8, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h01, 32'h01);
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h50);
    usc_line_model_i.send(9'h0a5, 8, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h05, 32'h05);
    rchk(usc_pkg::RXDATA_OFS, 32'hff, 32'ha5);
  endtask

  // receiver off: frame ignored
  task automatic t_ren();
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h80);
    usc_line_model_i.send(9'h13c, 9, 1'b1, 32);
    rchk(usc_pkg::SERIAL_CONTROL_OFS, 32'h01, 32'h0);
    rchk(usc_pkg::RXDATA_OFS, 32'hff, 32'ha5);
  endtask

  // fill the fifo until it stalls the bus, then drain it in order
  task automatic t_fifo();
    wr(usc_pkg::POWER_CONTROL_OFS, 32'h80);
    wr(usc_pkg::SERIAL_CONTROL_OFS, 32'h80);
    stalls = 0;
    fork
      for (int i = 0; i < 18; i++) wr(usc_pkg::TXDATA_OFS, 32'h40 + i);
      for (int j = 0; j < 18; j++) begin
        usc_line_model_i.grab(d, ok, 9, 16);
        chk({22'h0, ok, d}, 32'h240 + j);
      end
    join
    chk({31'h0, stalls > 0}, 32'h1);
    repeat (20) @(posedge pclk);
    rchk(usc_pkg::STATUS_OFS, 32'hff, 32'h0);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    pclk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer1_ovf = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode_bits();
    t_shift();
    t_timer();
    t_tx9(32'h80, 32'h00, 32);
    t_tx9(32'h80, 32'h80, 16);
    t_tx9(32'hc0, 32'h00, 32);
    t_rx9(32'h80);
    t_rx9(32'hc0);
    t_rx8();
    t_ren();
    t_fifo();
    end_sim();
  end

  // hang guard
  initial begin
    #(50 * 100000);
    num_errors++;
    end_sim();
  end
endmodule // usc_top_test
